/* File: src/sssie_pkg.sv */
// Constants, register map and carrier types of the borrow-subtract, set and skip unit.
package sssie_pkg;

  // Flag bit positions inside the flag register.
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;

  // Bus register map, byte addresses.
  localparam int unsigned AXI_AW       = 12;
  localparam logic [11:0] REG_CTRL_OFS = 12'h000;
  localparam logic [11:0] REG_FLAG_OFS = 12'h004;
  localparam logic [11:0] REG_PC_OFS   = 12'h008;
  localparam logic [11:0] REG_IO_BASE  = 12'h080;
  localparam logic [11:0] REG_GP_BASE  = 12'h100;
  localparam int unsigned CTRL_ALT_BIT = 0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Reset values.
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  FLAG_RST = 8'h00;
  localparam logic [7:0]  DATA_RST = 8'h00;

  // Cycle counts and program counter steps.
  localparam logic [2:0] CYC_BASE      = 3'h1;
  localparam logic [2:0] CYC_WORD_SUB  = 3'h2;
  localparam logic [2:0] CYC_IO_SET    = 3'h2;
  localparam logic [2:0] CYC_IO_SET_AL = 3'h1;
  localparam logic [2:0] CYC_ALT_EXTRA = 3'h1;
  localparam logic [1:0] STEP_NONE     = 2'h1;
  localparam logic [1:0] STEP_SHORT    = 2'h2;
  localparam logic [1:0] STEP_LONG     = 2'h3;

  // Opcode patterns.
  localparam logic [5:0] OPC_SUB_REG   = 6'h02;
  localparam logic [3:0] OPC_SUB_IMM   = 4'h4;
  localparam logic [3:0] OPC_OR_IMM    = 4'h6;
  localparam logic [7:0] OPC_SUB_WORD  = 8'h97;
  localparam logic [7:0] OPC_IO_SET    = 8'h9a;
  localparam logic [7:0] OPC_SKIP_IOC  = 8'h99;
  localparam logic [7:0] OPC_SKIP_IOS  = 8'h9b;
  localparam logic [6:0] OPC_SKIP_RGC  = 7'h7e;
  localparam logic [6:0] OPC_LONG_MEM  = 7'h48;
  localparam logic [6:0] OPC_LONG_JMP  = 7'h4a;

  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] follow;
  } sssie_fetch_t;

  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } sssie_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } sssie_axi_rsp_t;

endpackage : sssie_pkg

/* File: src/sssie_core.sv */
// Execution unit for borrow-subtract, word subtract, OR mask, I/O bit set and bit skips.
// What this block does
// - Register borrow-subtract writes Rd minus src minus C.
// - Immediate borrow-subtract writes Rd minus K minus C.
// - Borrow-subtract zero flag only sticks when zero.
// - Borrow-subtract half carry marks borrow from bit 3.
// - Register form carry: src plus C exceeds Rd.
// - Immediate form carry: K plus C exceeds Rd.
// - Overflow is two's complement; sign is N xor V.
// - Negative copies result MSB, bit 7 or 15.
// - I/O set forces bit b of I/O 0-31.
// - Skip when I/O bit reads zero.
// - Skip when I/O bit reads one.
// - Skip when general register bit is zero.
// - Skip steps PC by 1, 2 or 3.
// - Skips take 1-3 cycles, alternate I/O 2-4.
// - Word subtract: upper pair minus 0-63, 2 cycles.
// - Word subtract zero on 16-bit zero, carry on borrow.
// - OR mask into r16-r31, V cleared, C kept.
`timescale 1ns/1ps

module sssie_core
  import sssie_pkg::*;
#(
  parameter int unsigned PC_W = 16
) (
  input  wire logic            clk_i,
  input  wire logic            sys_rst_i,
  input  wire logic            fetch_valid_i,
  input  wire sssie_fetch_t    fetch_i,
  output logic                 fetch_ready_o,
  output logic                 retire_o,
  output logic [PC_W-1:0]      pc_o,
  output logic [7:0]           flag_register_o,
  input  wire sssie_axi_req_t  axi_i,
  output sssie_axi_rsp_t       axi_o
);

  if (PC_W < 16 || PC_W > 22) begin : g_pc_check
    $error("PC_W must lie between 16 and 22.");
  end

  typedef enum logic {ST_IDLE, ST_HOLD} sssie_state_t;

  logic [7:0]      gp_r [32];
  logic [7:0]      io_r [32];
  logic [7:0]      flag_r;
  logic [PC_W-1:0] pc_r;
  logic [7:0]      ctrl_r;
  logic            ready_r;
  logic            retire_r;
  logic [2:0]      wait_r;
  sssie_state_t    state_r;
  logic            awready_r;
  logic            wready_r;
  logic            bvalid_r;
  logic [1:0]      bresp_r;
  logic            arready_r;
  logic            rvalid_r;
  logic [31:0]     rdata_r;
  logic [1:0]      rresp_r;
  logic            aw_got_r;
  logic            w_got_r;
  logic [11:0]     awaddr_r;
  logic [31:0]     wdata_r;
  logic [3:0]      wstrb_r;

  logic        take;
  logic [15:0] op;
  logic        is_sub_reg, is_sub_imm, is_or_imm, is_sub_word;
  logic        is_io_set, is_skip_ioc, is_skip_ios, is_skip_rgc;
  logic        alt_core;
  logic [4:0]  dst_idx;
  logic [7:0]  dst, opnd, res8;
  logic [8:0]  diff;
  logic [4:0]  pair_lo;
  logic [15:0] pair, wres;
  logic        bit_io, bit_gp, skip, follow_long;
  logic [7:0]  flag_nxt;
  logic        flag_we, gp_we, pair_we;
  logic [1:0]  step;
  logic [2:0]  cyc;

  assign op       = fetch_i.instr;
  assign take     = fetch_valid_i & ready_r;
  assign alt_core = ctrl_r[CTRL_ALT_BIT];

  assign is_sub_reg  = op[15:10] == OPC_SUB_REG;
  assign is_sub_imm  = op[15:12] == OPC_SUB_IMM;
  assign is_or_imm   = op[15:12] == OPC_OR_IMM;
  assign is_sub_word = op[15:8] == OPC_SUB_WORD;
  assign is_io_set   = op[15:8] == OPC_IO_SET;
  assign is_skip_ioc = op[15:8] == OPC_SKIP_IOC;
  assign is_skip_ios = op[15:8] == OPC_SKIP_IOS;
  assign is_skip_rgc = (op[15:9] == OPC_SKIP_RGC) && !op[3];

  // Only direct memory and absolute call forms (bits 3:1 all ones) occupy two words.
  assign follow_long = ((fetch_i.follow[15:9] == OPC_LONG_MEM) && (fetch_i.follow[3:0] == 4'h0))
                     | ((fetch_i.follow[15:9] == OPC_LONG_JMP)
                        && (fetch_i.follow[3:1] == 3'h7));

  always_comb begin
    dst_idx  = is_sub_reg ? op[8:4] : {1'b1, op[7:4]};
    dst      = gp_r[dst_idx];
    opnd     = is_sub_reg ? gp_r[{op[9], op[3:0]}] : {op[11:8], op[3:0]};
    diff     = {1'b0, dst} - {1'b0, opnd} - {8'h00, flag_r[FLG_C]};
    pair_lo  = {2'b11, op[5:4], 1'b0};
    pair     = {gp_r[pair_lo | 5'h01], gp_r[pair_lo]};
    wres     = pair - {10'h000, op[7:6], op[3:0]};
    bit_io   = io_r[op[7:3]][op[2:0]];
    bit_gp   = gp_r[op[8:4]][op[2:0]];
    res8     = diff[7:0];
    flag_nxt = flag_r;
    flag_we  = 1'b0;
    gp_we    = 1'b0;
    pair_we  = 1'b0;
    if (is_sub_reg || is_sub_imm) begin
      gp_we = 1'b1;
      flag_we = 1'b1;
      flag_nxt[FLG_H] = (~dst[3] & opnd[3]) | (opnd[3] & res8[3])
                      | (res8[3] & ~dst[3]);
      flag_nxt[FLG_V] = (dst[7] & ~opnd[7] & ~res8[7])
                      | (~dst[7] & opnd[7] & res8[7]);
      flag_nxt[FLG_N] = res8[7];
      flag_nxt[FLG_Z] = (res8 == 8'h00) & flag_r[FLG_Z];
      flag_nxt[FLG_C] = (~dst[7] & opnd[7]) | (opnd[7] & res8[7])
                      | (res8[7] & ~dst[7]);
    end else if (is_or_imm) begin
      res8 = dst | opnd;
      gp_we = 1'b1;
      flag_we = 1'b1;
      flag_nxt[FLG_V] = 1'b0;
      flag_nxt[FLG_N] = res8[7];
      flag_nxt[FLG_Z] = res8 == 8'h00;
    end else if (is_sub_word) begin
      pair_we = 1'b1;
      flag_we = 1'b1;
      flag_nxt[FLG_V] = pair[15] & ~wres[15];
      flag_nxt[FLG_N] = wres[15];
      flag_nxt[FLG_Z] = wres == 16'h0000;
      flag_nxt[FLG_C] = wres[15] & ~pair[15];
    end
    flag_nxt[FLG_S] = flag_we ? (flag_nxt[FLG_N] ^ flag_nxt[FLG_V]) : flag_r[FLG_S];
  end

  // Skipping only moves the PC; the skipped word is never executed here.
  assign skip = (is_skip_ioc & ~bit_io) | (is_skip_ios & bit_io)
              | (is_skip_rgc & ~bit_gp);

  always_comb begin
    step = STEP_NONE;
    cyc  = CYC_BASE;
    if (skip) begin
      step = follow_long ? STEP_LONG : STEP_SHORT;
      cyc  = {1'b0, step};
    end
    if (alt_core && (is_skip_ioc || is_skip_ios)) begin
      cyc = cyc + CYC_ALT_EXTRA;
    end
    if (is_sub_word) begin
      cyc = CYC_WORD_SUB;
    end
    if (is_io_set) begin
      cyc = alt_core ? CYC_IO_SET_AL : CYC_IO_SET;
    end
  end

  // Effects commit at acceptance; the hold state only stretches the cycle count.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r  <= ST_IDLE;
      ready_r  <= 1'b1;
      retire_r <= 1'b0;
      wait_r   <= 3'h0;
    end else begin
      retire_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (take) begin
            if (cyc == CYC_BASE) begin
              retire_r <= 1'b1;
            end else begin
              ready_r <= 1'b0;
              wait_r  <= cyc - CYC_BASE;
              state_r <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          wait_r <= wait_r - 3'h1;
          if (wait_r == 3'h1) begin
            ready_r  <= 1'b1;
            retire_r <= 1'b1;
            state_r  <= ST_IDLE;
          end
        end
      endcase
    end
  end

  logic wr_do;
  logic wr_ctrl, wr_flag, wr_pc, wr_io, wr_gp;
  assign wr_do   = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_ctrl = awaddr_r[11:2] == REG_CTRL_OFS[11:2];
  assign wr_flag = awaddr_r[11:2] == REG_FLAG_OFS[11:2];
  assign wr_pc   = awaddr_r[11:2] == REG_PC_OFS[11:2];
  assign wr_io   = awaddr_r[11:7] == REG_IO_BASE[11:7];
  assign wr_gp   = awaddr_r[11:7] == REG_GP_BASE[11:7];

  // An instruction and a bus write in the same cycle: the instruction wins the register.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pc_r <= '0;
    end else if (take) begin
      pc_r <= pc_r + PC_W'(step);
    end else if (wr_do && wr_pc) begin
      if (wstrb_r[0]) begin
        pc_r[7:0] <= wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        pc_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_r <= FLAG_RST;
    end else if (take && flag_we) begin
      flag_r <= flag_nxt;
    end else if (wr_do && wr_flag && wstrb_r[0]) begin
      flag_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_do && wr_ctrl && wstrb_r[0]) begin
      ctrl_r <= wdata_r[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 32; i++) begin
        gp_r[i] <= DATA_RST;
      end
    end else if (take && gp_we) begin
      gp_r[dst_idx] <= res8;
    end else if (take && pair_we) begin
      gp_r[pair_lo]         <= wres[7:0];
      gp_r[pair_lo | 5'h01] <= wres[15:8];
    end else if (wr_do && wr_gp && wstrb_r[0]) begin
      gp_r[awaddr_r[6:2]] <= wdata_r[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 32; i++) begin
        io_r[i] <= DATA_RST;
      end
    end else if (take && is_io_set) begin
      io_r[op[7:3]][op[2:0]] <= 1'b1;
    end else if (wr_do && wr_io && wstrb_r[0]) begin
      io_r[awaddr_r[6:2]] <= wdata_r[7:0];
    end
  end

  // Write channels: address and data are held until both arrived, then one response.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (axi_i.awvalid && awready_r) begin
        aw_got_r  <= 1'b1;
        awaddr_r  <= axi_i.awaddr;
        awready_r <= 1'b0;
      end
      if (axi_i.wvalid && wready_r) begin
        w_got_r  <= 1'b1;
        wdata_r  <= axi_i.wdata;
        wstrb_r  <= axi_i.wstrb;
        wready_r <= 1'b0;
      end
      if (wr_do) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_ctrl | wr_flag | wr_pc | wr_io | wr_gp) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && axi_i.bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  logic [31:0] rd_data;
  logic        rd_ok;
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (axi_i.araddr[11:2] == REG_CTRL_OFS[11:2]) begin
      rd_data[7:0] = ctrl_r;
    end else if (axi_i.araddr[11:2] == REG_FLAG_OFS[11:2]) begin
      rd_data[7:0] = flag_r;
    end else if (axi_i.araddr[11:2] == REG_PC_OFS[11:2]) begin
      rd_data[PC_W-1:0] = pc_r;
    end else if (axi_i.araddr[11:7] == REG_IO_BASE[11:7]) begin
      rd_data[7:0] = io_r[axi_i.araddr[6:2]];
    end else if (axi_i.araddr[11:7] == REG_GP_BASE[11:7]) begin
      rd_data[7:0] = gp_r[axi_i.araddr[6:2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (axi_i.arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_data;
      rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && axi_i.rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign fetch_ready_o   = ready_r;
  assign retire_o        = retire_r;
  assign pc_o            = pc_r;
  assign flag_register_o = flag_r;
  // Each channel's flops live in one process; the struct is only assembled here.
  assign axi_o           = '{awready: awready_r, wready: wready_r, bresp: bresp_r,
                             bvalid: bvalid_r, arready: arready_r, rdata: rdata_r,
                             rresp: rresp_r, rvalid: rvalid_r};

endmodule : sssie_core

/* File: tb/sssie_core_properties.sv */
// Concurrent checks on the ports of the borrow-subtract, set and skip unit.
`timescale 1ns/1ps
module sssie_core_properties
  import sssie_pkg::*;
#(
  parameter int unsigned PC_W = 16
) (
  input wire logic            clk_i,
  input wire logic            sys_rst_i,
  input wire logic            fetch_valid_i,
  input wire sssie_fetch_t    fetch_i,
  input wire logic            fetch_ready_o,
  input wire logic            retire_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [7:0]      flag_register_o
);
  logic tk;
  logic rs;
  logic sk;
  logic sb;
  logic ws;
  logic om;
  assign tk = fetch_valid_i && fetch_ready_o;
  assign ws = tk && fetch_i.instr[15:8] == OPC_SUB_WORD;
  assign om = tk && fetch_i.instr[15:12] == OPC_OR_IMM;
  assign rs = tk && fetch_i.instr[15:9] == OPC_SKIP_RGC;
  assign sk = rs || (tk && fetch_i.instr[15:8] inside {OPC_SKIP_IOC, OPC_SKIP_IOS, OPC_IO_SET});
  assign sb = tk && (fetch_i.instr[15:10] == OPC_SUB_REG || fetch_i.instr[15:12] == OPC_SUB_IMM);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_word_sub_time: assert property (ws |=>
    !fetch_ready_o ##1 (fetch_ready_o && retire_o)) else $error("word subtract timing wrong");
  a_sub_sign: assert property (sb || om |=>
    flag_register_o[FLG_S] == (flag_register_o[FLG_N] ^ flag_register_o[FLG_V]))
    else $error("sign flag is not N xor V");
  a_or_flags: assert property (om |=>
    !flag_register_o[FLG_V] && flag_register_o[FLG_C] == $past(flag_register_o[FLG_C]))
    else $error("OR mask flags wrong");
  a_zero_sticky: assert property (sb && !flag_register_o[FLG_Z] |=>
    !flag_register_o[FLG_Z]) else $error("zero flag set from clear");
  a_skip_flags: assert property (sk |=> $stable(flag_register_o))
    else $error("flags changed by set or skip");
  a_skip_pc_step: assert property (sk |=>
    PC_W'(pc_o - $past(pc_o)) inside {1, 2, 3}) else $error("skip step out of range");
  a_long_skip_time: assert property (rs ##1 pc_o == $past(pc_o) + PC_W'(3) |->
    !fetch_ready_o ##1 !fetch_ready_o ##1 (fetch_ready_o && retire_o))
    else $error("long skip timing wrong");
  a_plain_skip: assert property (rs ##1 pc_o == $past(pc_o) + PC_W'(1) |->
    fetch_ready_o && retire_o) else $error("no-skip timing wrong");
endmodule : sssie_core_properties

/* File: tb/sssie_fetch_model.sv */
// Fetch-stage stand-in that offers one instruction with its following word.
`timescale 1ns/1ps
module sssie_fetch_model
  import sssie_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   fetch_ready_i,
  output logic        fetch_valid_o,
  output sssie_fetch_t fetch_o
);
  initial begin
    fetch_valid_o = 1'b0;
    fetch_o = '0;
  end
  // Idle words are inverted so stale data never passes for a fresh request.
  task automatic issue(input logic [15:0] ins, input logic [15:0] fol, input logic [1:0] gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    fetch_valid_o <= 1'b1;
    fetch_o <= {ins, fol};
    do @(posedge clk_i); while (fetch_ready_i !== 1'b1);
    fetch_valid_o <= 1'b0;
    fetch_o <= ~{ins, fol};
  endtask : issue
endmodule : sssie_fetch_model

/* File: tb/tb_sssie_core.sv */
// Random self-checking bench for the borrow-subtract, set and skip unit.
`timescale 1ns/1ps
module tb_sssie_core;
  import sssie_pkg::*;
  localparam int unsigned PC_W = 16;
  logic            clk_i = 1'b0;
  logic            sys_rst_i = 1'b1;
  logic            fetch_valid_i;
  logic            fetch_ready_o;
  logic            retire_o;
  sssie_fetch_t    fetch_i;
  logic [PC_W-1:0] pc_o;
  logic [PC_W-1:0] pc0;
  logic [7:0]      flag_register_o;
  sssie_axi_req_t  axi_i = '0;
  sssie_axi_rsp_t  axi_o;
  int              n_errors = 0;
  int              total_checks = 0;
  int              cyc = 0;
  int              seed = 8;
  int              n;
  logic [31:0]     d;
  logic [1:0]      rs;
  logic [28:0]     e;
  logic [15:0]     ins;
  logic [7:0]      a, b, h, fl;
  logic [4:0]      ra, rb;
  logic [2:0]      op, bt;
  logic            alt, lg, io;

  always #12.5 clk_i = ~clk_i;

  sssie_core #(.PC_W(PC_W)) i_sssie_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .fetch_valid_i(fetch_valid_i), .fetch_i(fetch_i), .fetch_ready_o(fetch_ready_o),
    .retire_o(retire_o), .pc_o(pc_o), .flag_register_o(flag_register_o),
    .axi_i(axi_i), .axi_o(axi_o));
  sssie_fetch_model i_sssie_fetch_model (.clk_i(clk_i), .fetch_ready_i(fetch_ready_o),
    .fetch_valid_o(fetch_valid_i), .fetch_o(fetch_i));

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] ad, input logic [31:0] dt, output logic [1:0] r);
    @(posedge clk_i);
    axi_i.awaddr <= ad;
    axi_i.wdata <= dt;
    axi_i.wstrb <= 4'hf;
    axi_i.awvalid <= 1'b1;
    axi_i.wvalid <= 1'b1;
    axi_i.bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (axi_o.awready) axi_i.awvalid <= 1'b0;
      if (axi_o.wready) axi_i.wvalid <= 1'b0;
    end while (axi_o.bvalid !== 1'b1);
    r = axi_o.bresp;
    axi_i.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] r);
    @(posedge clk_i);
    axi_i.araddr <= ad;
    axi_i.arvalid <= 1'b1;
    axi_i.rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (axi_o.arready) axi_i.arvalid <= 1'b0;
    end while (axi_o.rvalid !== 1'b1);
    dt = axi_o.rdata;
    r = axi_o.rresp;
    axi_i.rready <= 1'b0;
  endtask : rd

  function automatic logic [11:0] ga(input logic [4:0] r, input logic i);
    return (i ? REG_IO_BASE : REG_GP_BASE) + {5'h0, r, 2'h0};
  endfunction : ga

  // Packs cycles, PC step, flags and the 16-bit register image of one instruction.
  function automatic logic [28:0] mdl(input logic [2:0] o, input logic [7:0] x, y, z, f0,
      input logic [2:0] bi, input logic al, ln);
    logic [8:0] w;
    logic [4:0] q;
    logic [15:0] p, r;
    logic [7:0] f;
    logic [2:0] cy;
    logic [1:0] st;
    logic v, sk;
    f = f0;
    cy = 3'h1;
    st = 2'h1;
    r = {z, x};
    sk = 1'b0;
    case (o)
      3'h0, 3'h1: begin
        w = {1'b0, x} - {1'b0, y} - f0[0];
        q = {1'b0, x[3:0]} - {1'b0, y[3:0]} - f0[0];
        v = (x[7] & ~y[7] & ~w[7]) | (~x[7] & y[7] & w[7]);
        f[5:0] = {q[4], w[7] ^ v, v, w[7], w[7:0] == 8'h0 && f0[1], w[8]};
        r[7:0] = w[7:0];
      end
      3'h2: begin
        r[7:0] = x | y;
        f[4:1] = {r[7], 1'b0, r[7], r[7:0] == 8'h0};
      end
      3'h3: begin
        p = {z, x} - {10'h0, y[5:0]};
        v = z[7] & ~p[15];
        f[4:0] = {p[15] ^ v, v, p[15], p == 16'h0, p[15] & ~z[7]};
        r = p;
        cy = 3'h2;
      end
      3'h4: begin
        r[7:0] = x | (8'h1 << bi);
        cy = al ? 3'h1 : 3'h2;
      end
      default: sk = (o == 3'h6) == x[bi];
    endcase
    if (sk) st = ln ? 2'h3 : 2'h2;
    // The alternate timing only stretches the two I/O skips by one cycle.
    if (o > 3'h4) cy = {1'b0, st} + (al && o != 3'h7);
    return {cy, st, f, r};
  endfunction : mdl

  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk(pc_o, 0);
    chk(flag_register_o, 0);
    chk(fetch_ready_o, 1);
    rd(REG_CTRL_OFS, d, rs);
    chk(d, 0);
    rd(12'hffc, d, rs);
    chk(rs, RESP_SLVERR);
    chk(d, 0);
    wr(12'h00c, 32'h5a, rs);
    chk(rs, RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 150; i++) begin
      op = 3'($random(seed));
      a = 8'($random(seed));
      b = 8'($random(seed));
      h = 8'($random(seed));
      fl = {2'h0, 6'($random(seed))};
      bt = 3'($random(seed));
      {alt, lg, ra, rb} = 12'($random(seed));
      // Every fifth pass aims for a zero result so the sticky zero flag is exercised.
      if (i % 5 == 0) b = a - fl[0];
      if (op == 3'h0 && ra == rb) b = a;
      if (op inside {3'h1, 3'h2}) ra[4] = 1'b1;
      if (op == 3'h3) ra = {2'h3, ra[1:0], 1'b0};
      io = op inside {[3'h4:3'h6]};
      case (op)
        3'h0: ins = {OPC_SUB_REG, rb[4], ra, rb[3:0]};
        3'h1: ins = {OPC_SUB_IMM, b[7:4], ra[3:0], b[3:0]};
        3'h2: ins = {OPC_OR_IMM, b[7:4], ra[3:0], b[3:0]};
        3'h3: ins = {OPC_SUB_WORD, b[5:4], ra[2:1], b[3:0]};
        3'h4: ins = {OPC_IO_SET, ra, bt};
        3'h5: ins = {OPC_SKIP_IOC, ra, bt};
        3'h6: ins = {OPC_SKIP_IOS, ra, bt};
        default: ins = {OPC_SKIP_RGC, ra, 1'b0, bt};
      endcase
      wr(REG_CTRL_OFS, {31'h0, alt}, rs);
      wr(REG_FLAG_OFS, {24'h0, fl}, rs);
      chk(rs, RESP_OKAY);
      wr(ga(ra, io), {24'h0, a}, rs);
      if (op == 3'h0) wr(ga(rb, 1'b0), {24'h0, b}, rs);
      if (op == 3'h3) wr(ga(ra + 5'h1, 1'b0), {24'h0, h}, rs);
      e = mdl(op, a, b, h, fl, bt, alt, lg);
      pc0 = pc_o;
      i_sssie_fetch_model.issue(ins, lg ? (bt[0] ? 16'h940e : 16'h9000) : 16'h0000, 2'(i));
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (retire_o !== 1'b1 && n < 8);
      chk(n, e[28:26]);
      chk(pc_o - pc0, e[25:24]);
      chk(flag_register_o, e[23:16]);
      rd(ga(ra, io), d, rs);
      chk(d, e[7:0]);
      if (op == 3'h3) begin
        rd(ga(ra + 5'h1, 1'b0), d, rs);
        chk(d, e[15:8]);
      end
      $display("test %0d op %0d done", i, op);
    end
    // A word outside the decoded set must only step the PC, in one cycle.
    pc0 = pc_o;
    fl = flag_register_o;
    i_sssie_fetch_model.issue(16'h0000, 16'h0000, 2'h0);
    @(posedge clk_i);
    chk(retire_o, 1);
    chk(pc_o - pc0, 1);
    chk(flag_register_o, fl);
    $display("test unknown opcode done");
    end_sim();
  end
endmodule : tb_sssie_core

bind sssie_core sssie_core_properties #(.PC_W(PC_W)) i_sssie_core_properties (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .fetch_valid_i(fetch_valid_i), .fetch_i(fetch_i),
  .fetch_ready_o(fetch_ready_o), .retire_o(retire_o), .pc_o(pc_o),
  .flag_register_o(flag_register_o));
